// [hdl/idf_pkg.sv]
// idf_pkg: constants shared by the input debounce filter block
package idf_pkg;

    // ************************************************************
    // input population
    // ************************************************************
    localparam int unsigned NUM_PROG  = 6;   // programmable-function inputs
    localparam int unsigned NUM_TRIG  = 8;   // inter-device trigger lines
    localparam int unsigned NUM_CHAN  = NUM_PROG + NUM_TRIG + 1; // plus star line
    localparam int unsigned SEL_W     = 3;   // width of an input index field

    // ************************************************************
    // filter clock timing
    // ************************************************************
    localparam int unsigned PCLK_MHZ   = 50;  // system clock rate
    localparam int unsigned FILT_MHZ   = 40;  // filter sample rate
    localparam int unsigned PCLK_NS    = 1000 / PCLK_MHZ; // 20 ns period
    localparam int unsigned JITTER_NS  = 25;  // worst lag spread, short settings
    localparam int unsigned ACC_W      = 6;   // rate accumulator width
    localparam logic [5:0]  ACC_ADD    = 6'(FILT_MHZ);
    localparam logic [5:0]  ACC_MOD    = 6'(PCLK_MHZ);

    // ************************************************************
    // filter settings and sample counts
    // ************************************************************
    typedef enum logic [1:0] {
        IDF_OFF   = 2'b00,  // unfiltered
        IDF_SHORT = 2'b01,  // 125 ns setting
        IDF_MID   = 2'b10,  // 6.425 us setting
        IDF_LONG  = 2'b11   // 2.55 ms setting
    } idf_set_t;

    localparam int unsigned CNT_W   = 17;
    localparam logic [16:0] N_SHORT = 17'h00005;  // 5 samples
    localparam logic [16:0] N_MID   = 17'h00101;  // 257 samples
    localparam int unsigned N_LONG  = 101800;     // about 101,800 samples

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [11:0] OFS_CFG   = 12'h000;  // settings, 2 bits per input
    localparam logic [11:0] OFS_ROUTE = 12'h004;  // direct unfiltered routing
    localparam logic [11:0] OFS_FILT  = 12'h008;  // filtered levels
    localparam logic [11:0] OFS_RAW   = 12'h00C;  // sampled raw levels
    localparam logic [29:0] CFG_RST   = 30'h00000000;
    localparam logic [11:0] ROUTE_RST = 12'h000;
    // route field positions
    localparam int unsigned RT_P_SRC  = 0;   // [2:0] programmable source
    localparam int unsigned RT_T_TGT  = 4;   // [6:4] trigger line target
    localparam int unsigned RT_P2T_EN = 7;
    localparam int unsigned RT_T_SRC  = 8;   // [10:8] trigger line source
    localparam int unsigned RT_T2P_EN = 11;

endpackage : idf_pkg

// [hdl/idf_tick.sv]
// idf_tick: fractional divider giving the 40 MHz filter sample enable
`timescale 1ns/1ns
module idf_tick
    import idf_pkg::*;
(
    input  wire logic pclk,     // system clock
    input  wire logic presetn,  // async reset, active low
    output logic      tick      // sample enable, high four cycles in every five
);

    logic [ACC_W-1:0] acc_r;
    logic [ACC_W:0]   acc_sum;  // one spare bit: 49 + 40 must not wrap

    // R02: R10: accumulate the filter rate, wrap at the system rate
    assign acc_sum = {1'b0, acc_r} + {1'b0, ACC_ADD};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r <= '0;
            tick  <= 1'b0;
        end else if (acc_sum >= {1'b0, ACC_MOD}) begin
            acc_r <= ACC_W'(acc_sum - {1'b0, ACC_MOD});
            tick  <= 1'b1;
        end else begin
            acc_r <= acc_sum[ACC_W-1:0];
            tick  <= 1'b0;
        end
    end

    // R02: four ticks in five clocks
    chk_tick_no_gap2: assert property (@(posedge pclk) disable iff (!presetn) // R02
        $fell(tick) |=> tick)
        else $error("filter tick missed two cycles");

    // R10: gap after four ticks keeps spacing
    chk_tick_gap: assert property (@(posedge pclk) disable iff (!presetn) // R10
        tick[*4] |=> !tick)
        else $error("filter tick ran faster than 40 MHz");

endmodule : idf_tick

// [hdl/idf_chan.sv]
// idf_chan: one debounce channel with selectable sample count
`timescale 1ns/1ns
module idf_chan
    import idf_pkg::*;
(
    input  wire logic             pclk,     // system clock
    input  wire logic             presetn,  // async reset, active low
    input  wire logic             tick,     // filter sample enable
    input  wire logic [1:0]       set_i,    // filter setting
    input  wire logic [CNT_W-1:0] n_long,   // count for the long setting
    input  wire logic             din,      // raw input level
    output logic                  level     // filtered level
);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] n_sel;

    // R05: R06: sample count for the current setting
    always_comb begin
        case (set_i)
            IDF_SHORT: n_sel = N_SHORT;
            IDF_MID:   n_sel = N_MID;
            IDF_LONG:  n_sel = n_long;
            default:   n_sel = N_SHORT;
        endcase
    end

    // R03: R04: R11: count differing samples, restart on a match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= 1'b0;
            cnt_r <= '0;
        end else if (set_i == IDF_OFF) begin
            // R06: disabled passes the input unfiltered
            level <= din;
            cnt_r <= '0;
        end else if (tick) begin
            if (din == level) begin
                cnt_r <= '0;
            end else if (cnt_r >= n_sel - 1'b1) begin  // also ends a count from a longer setting
                level <= din;
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    // R11: output holds between samples
    chk_hold_level: assert property (@(posedge pclk) disable iff (!presetn) // R11
        (set_i != IDF_OFF && !tick) |=> $stable(level))
        else $error("filtered level moved without a sample");

    // R03: change passes on the Nth sample
    chk_pass_nth: assert property (@(posedge pclk) disable iff (!presetn) // R03
        (set_i != IDF_OFF && tick && din != level && cnt_r == n_sel - 1'b1)
        |=> level == $past(din))
        else $error("level not passed on the Nth sample");

    // R06: disabled setting is transparent
    chk_bypass: assert property (@(posedge pclk) disable iff (!presetn) // R06
        (set_i == IDF_OFF) |=> level == $past(din))
        else $error("disabled filter did not pass input");

    // R04: matching sample restarts the count
    chk_cnt_restart: assert property (@(posedge pclk) disable iff (!presetn) // R04
        (set_i != IDF_OFF && tick && din == level) |=> cnt_r == '0)
        else $error("count not restarted on matching sample");

    // R05: short setting never passes on the first differing sample
    chk_short_min: assert property (@(posedge pclk) disable iff (!presetn) // R05
        (set_i == IDF_SHORT && tick && din != level && cnt_r == '0)
        |=> level == $past(level))
        else $error("short setting passed a change too early");

endmodule : idf_chan

// [hdl/idf_top.sv]
// idf_top: input debounce filters with APB registers and direct routing
// Notes on behaviour
// R01: every programmable input, trigger line and star line has its own filter
// R02: enabled filters sample their input on each 40 MHz filter tick
// R03: a rise passes only after N consecutive high samples
// R04: a fall passes only after N consecutive low samples
// R05: shortest setting needs 5 samples: 125 ns passes, 100 ns rejected
// R06: settings are 5, 257, about 101,800 samples, or disabled and unfiltered
// R07: each input keeps and applies its own setting
// R08: all filters come out of reset disabled
// R09: direct routing between programmable inputs and trigger lines is unfiltered
// R10: short settings add no more than 25 ns of jitter
// R11: a matching sample restarts the count; output holds until count reaches N
`timescale 1ns/1ns
module idf_top
    import idf_pkg::*;
#(
    parameter int unsigned N_LONG_P = N_LONG  // long-setting sample count
)(
    input  wire logic                pclk,          // system clock, 50 MHz
    input  wire logic                presetn,       // async reset, active low
    input  wire logic                psel,          // APB select
    input  wire logic                penable,       // APB access phase
    input  wire logic                pwrite,        // APB write
    input  wire logic [11:0]         paddr,         // APB byte address
    input  wire logic [31:0]         pwdata,        // APB write data
    input  wire logic [3:0]          pstrb,         // APB byte strobes
    output logic      [31:0]         prdata,        // APB read data
    output logic                     pready,        // APB ready
    output logic                     pslverr,       // APB error
    input  wire logic [NUM_PROG-1:0] prog_in,       // programmable-function inputs
    input  wire logic [NUM_TRIG-1:0] trig_in,       // trigger line inputs
    input  wire logic                star_in,       // star trigger input
    output logic      [NUM_PROG-1:0] prog_filt,     // filtered programmable inputs
    output logic      [NUM_TRIG-1:0] trig_filt,     // filtered trigger lines
    output logic                     star_filt,     // filtered star line
    output logic      [NUM_TRIG-1:0] fwd_trig_out,  // trigger line drive level
    output logic      [NUM_TRIG-1:0] fwd_trig_oe,   // trigger line drive enable
    output logic                     fwd_prog_out,  // forwarded trigger level
    output logic                     fwd_prog_oe    // forwarded trigger enable
);

    // ************************************************************
    // declarations
    // ************************************************************
    localparam logic [CNT_W-1:0] N_LONG_C = CNT_W'(N_LONG_P);

    logic [2*NUM_CHAN-1:0] cfg_r;        // per-input settings
    logic [2*NUM_CHAN-1:0] cfg_nxt;
    logic [11:0]           route_r;      // direct routing control
    logic [11:0]           route_nxt;
    logic [31:0]           prdata_r;
    logic                  pslverr_r;
    logic [31:0]           rd_word;
    logic                  addr_ok;
    logic                  setup_ph;
    logic                  access_ph;
    logic                  wr_cfg;
    logic                  wr_route;
    logic                  tick;
    logic [NUM_CHAN-1:0]   raw_vec;
    logic [NUM_CHAN-1:0]   filt_vec;
    logic [NUM_CHAN-1:0]   raw_r;        // raw levels seen by software
    logic [SEL_W-1:0]      p_src;
    logic [SEL_W-1:0]      t_tgt;
    logic [SEL_W-1:0]      t_src;
    logic                  p_src_lvl;
    logic                  t_src_lvl;

    // ************************************************************
    // APB decode
    // ************************************************************

    // phases of a transfer
    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;

    // address check for the four mapped words
    always_comb begin
        case (paddr)
            OFS_CFG:   addr_ok = 1'b1;
            OFS_ROUTE: addr_ok = 1'b1;
            OFS_FILT:  addr_ok = 1'b1;
            OFS_RAW:   addr_ok = 1'b1;
            default:   addr_ok = 1'b0;
        endcase
    end

    // write strobes, only at the access phase
    assign wr_cfg   = access_ph && pwrite && (paddr == OFS_CFG);
    assign wr_route = access_ph && pwrite && (paddr == OFS_ROUTE);

    // slave never stretches a transfer
    assign pready  = 1'b1;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;

    // read data mux
    always_comb begin
        case (paddr)
            OFS_CFG:   rd_word = {2'b00, cfg_r};
            OFS_ROUTE: rd_word = {20'h00000, route_r};
            OFS_FILT:  rd_word = {17'h00000, filt_vec};
            OFS_RAW:   rd_word = {17'h00000, raw_r};
            default:   rd_word = 32'h00000000;
        endcase
    end

    // read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            prdata_r  <= pwrite ? 32'h00000000 : rd_word;
            pslverr_r <= !addr_ok;
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************

    // byte-lane merge for the settings word
    always_comb begin
        cfg_nxt = cfg_r;
        if (pstrb[0]) begin
            cfg_nxt[7:0] = pwdata[7:0];
        end
        if (pstrb[1]) begin
            cfg_nxt[15:8] = pwdata[15:8];
        end
        if (pstrb[2]) begin
            cfg_nxt[23:16] = pwdata[23:16];
        end
        if (pstrb[3]) begin
            cfg_nxt[29:24] = pwdata[29:24];
        end
    end

    // byte-lane merge for the route word
    always_comb begin
        route_nxt = route_r;
        if (pstrb[0]) begin
            route_nxt[7:0] = pwdata[7:0];
        end
        if (pstrb[1]) begin
            route_nxt[11:8] = pwdata[11:8];
        end
    end

    // R08: R07: settings start disabled, one field per input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= CFG_RST;
        end else if (wr_cfg) begin
            cfg_r <= cfg_nxt;
        end
    end

    // routing control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_r <= ROUTE_RST;
        end else if (wr_route) begin
            route_r <= route_nxt;
        end
    end

    // ************************************************************
    // filter channels
    // ************************************************************

    // shared 40 MHz sample enable
    idf_tick u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    // channel order: programmable inputs, trigger lines, star line
    assign raw_vec = {star_in, trig_in, prog_in};

    // R01: one independent filter per input
    generate
        for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
            idf_chan u_chan (
                .pclk    (pclk),
                .presetn (presetn),
                .tick    (tick),
                .set_i   (cfg_r[2*i+1:2*i]),
                .n_long  (N_LONG_C),
                .din     (raw_vec[i]),
                .level   (filt_vec[i])
            );
        end
    endgenerate

    // filtered outputs to internal logic
    assign prog_filt = filt_vec[NUM_PROG-1:0];
    assign trig_filt = filt_vec[NUM_PROG+NUM_TRIG-1:NUM_PROG];
    assign star_filt = filt_vec[NUM_CHAN-1];

    // raw level snapshot for status reads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_r <= '0;
        end else begin
            raw_r <= raw_vec;
        end
    end

    // ************************************************************
    // direct routing
    // ************************************************************
    assign p_src = route_r[RT_P_SRC +: SEL_W];
    assign t_tgt = route_r[RT_T_TGT +: SEL_W];
    assign t_src = route_r[RT_T_SRC +: SEL_W];

    // source levels; an out-of-range programmable index reads low
    assign p_src_lvl = (p_src < SEL_W'(NUM_PROG)) ? prog_in[p_src] : 1'b0;
    assign t_src_lvl = trig_in[t_src];

    // R09: forwarding takes the raw level, never the filtered one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_trig_out <= '0;
            fwd_trig_oe  <= '0;
            fwd_prog_out <= 1'b0;
            fwd_prog_oe  <= 1'b0;
        end else begin
            for (int k = 0; k < NUM_TRIG; k++) begin
                fwd_trig_oe[k]  <= route_r[RT_P2T_EN] && (t_tgt == SEL_W'(k));
                fwd_trig_out[k] <= route_r[RT_P2T_EN] && (t_tgt == SEL_W'(k))
                                   && p_src_lvl;
            end
            fwd_prog_oe  <= route_r[RT_T2P_EN];
            fwd_prog_out <= route_r[RT_T2P_EN] && t_src_lvl;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************

    // R08: settings read disabled right after reset
    chk_reset_off: assert property (@(posedge pclk) disable iff (!presetn) // R08
        !$past(presetn) |-> cfg_r == CFG_RST)
        else $error("filter settings not disabled after reset");

    // R07: full write lands every field
    chk_cfg_write: assert property (@(posedge pclk) disable iff (!presetn) // R07
        (wr_cfg && pstrb == 4'hF) |=> cfg_r == $past(pwdata[29:0]))
        else $error("settings write not stored");

    // R07: settings hold without a write
    chk_cfg_hold: assert property (@(posedge pclk) disable iff (!presetn) // R07
        !wr_cfg |=> $stable(cfg_r))
        else $error("settings changed without a write");

    // R09: trigger forward follows raw source
    chk_route_p2t: assert property (@(posedge pclk) disable iff (!presetn) // R09
        (route_r[RT_P2T_EN] && p_src < SEL_W'(NUM_PROG))
        |=> fwd_trig_out[$past(t_tgt)] == $past(p_src_lvl)
            && fwd_trig_oe[$past(t_tgt)])
        else $error("trigger forward not unfiltered");

    // R09: reverse forward follows raw trigger
    chk_route_t2p: assert property (@(posedge pclk) disable iff (!presetn) // R09
        route_r[RT_T2P_EN] |=> fwd_prog_out == $past(t_src_lvl) && fwd_prog_oe)
        else $error("reverse forward not unfiltered");

    // R01: unmapped address answers with an error
    chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn) // R01
        (setup_ph && !addr_ok) |=> pslverr)
        else $error("unmapped access gave no error");

    // R03: filtered status read returns the filter levels
    chk_filt_read: assert property (@(posedge pclk) disable iff (!presetn) // R03
        (setup_ph && !pwrite && paddr == OFS_FILT)
        |=> prdata == {17'h00000, $past(filt_vec)})
        else $error("filtered status read wrong");

    // R09: route word holds without a write
    chk_route_hold: assert property (@(posedge pclk) disable iff (!presetn) // R09
        !wr_route |=> $stable(route_r))
        else $error("route word changed without a write");

    // R09: full route write lands every field
    chk_route_write: assert property (@(posedge pclk) disable iff (!presetn) // R09
        (wr_route && pstrb[1:0] == 2'h3) |=> route_r == $past(pwdata[11:0]))
        else $error("route write not stored");

    // R09: at most one trigger line driven
    chk_trig_onehot: assert property (@(posedge pclk) disable iff (!presetn) // R09
        $onehot0(fwd_trig_oe))
        else $error("more than one trigger line driven");

    // R09: forwarding off leaves lines undriven
    chk_fwd_off: assert property (@(posedge pclk) disable iff (!presetn) // R09
        !route_r[RT_P2T_EN] |=> fwd_trig_oe == '0)
        else $error("trigger line driven with forwarding off");

    // R01: mapped access answers without error
    chk_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn) // R01
        (setup_ph && addr_ok) |=> !pslverr)
        else $error("mapped access gave an error");

    // R09: raw snapshot trails the inputs
    chk_raw_snap: assert property (@(posedge pclk) disable iff (!presetn) // R09
        $past(presetn) |-> raw_r == $past(raw_vec))
        else $error("raw snapshot out of step");

endmodule : idf_top

// [testbench/idf_src_model.sv]
// idf_src_model: external trigger sources driving the raw filter inputs
`timescale 1ns/1ns
module idf_src_model
    import idf_pkg::*;
(
    input  wire logic                pclk,  // system clock
    output logic      [NUM_CHAN-1:0] raw    // raw levels, star line on top
);
    // all sources idle low until told otherwise
    initial raw = '0;

    // move one source to a level, just after a clock edge
    task automatic set_lvl(input int ch, input logic lvl);
        @(posedge pclk);
        raw[ch] <= lvl;
    endtask : set_lvl

    // hold a level for a number of cycles, then return to the other level
    task automatic pulse(input int ch, input logic lvl, input int cyc);
        @(posedge pclk);
        raw[ch] <= lvl;
        repeat (cyc) @(posedge pclk);
        raw[ch] <= ~lvl;
    endtask : pulse
endmodule : idf_src_model

// [testbench/test_input_debounce_filter.sv]
// test_input_debounce_filter: register and filter tests over APB
`timescale 1ns/1ns
module test_input_debounce_filter
    import idf_pkg::*;
;
    logic                pclk;
    logic                presetn;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [11:0]         paddr;
    logic [31:0]         pwdata;
    logic [3:0]          pstrb;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic [NUM_CHAN-1:0] raw;
    logic [NUM_CHAN-1:0] filt;
    logic [NUM_PROG-1:0] prog_filt;
    logic [NUM_TRIG-1:0] trig_filt;
    logic                star_filt;
    logic [NUM_TRIG-1:0] fwd_trig_out;
    logic [NUM_TRIG-1:0] fwd_trig_oe;
    logic                fwd_prog_out;
    logic                fwd_prog_oe;
    logic                any;
    int                  num_errors;
    int                  check_count;

    // 50 MHz system clock
    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    // long setting shortened to 20 samples to keep the run brief
    idf_top #(.N_LONG_P(20)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prog_in(raw[NUM_PROG-1:0]), .trig_in(raw[NUM_CHAN-2:NUM_PROG]),
        .star_in(raw[NUM_CHAN-1]), .prog_filt(prog_filt), .trig_filt(trig_filt),
        .star_filt(star_filt), .fwd_trig_out(fwd_trig_out), .fwd_trig_oe(fwd_trig_oe),
        .fwd_prog_out(fwd_prog_out), .fwd_prog_oe(fwd_prog_oe));

    idf_src_model src (.pclk(pclk), .raw(raw));

    assign filt = {star_filt, trig_filt, prog_filt};  // same order as the config fields

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    // one APB transfer; answer taken at the edge where pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // only the watchdog ends a wait
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic e_exp);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, s, q, e);
        check("write pslverr", {31'h0, e}, {31'h0, e_exp});
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic e_exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h00000000, 4'h0, q, e);
        check("read data", q, exp);
        check("read pslverr", {31'h0, e}, {31'h0, e_exp});
    endtask : rd_chk

    // watch one filtered output for any high level over a span of cycles
    task automatic probe(input int ch, input int cyc, output logic hit);
        hit = 1'b0;
        repeat (cyc) begin
            @(posedge pclk);
            if (filt[ch] === 1'b1) begin
                hit = 1'b1;
            end
        end
    endtask : probe

    // change a source, output must keep the old level at lo and show the new by hi
    task automatic step(input int ch, input logic lvl, input int lo, input int hi);
        src.set_lvl(ch, lvl);
        repeat (lo) @(posedge pclk);
        check("filt early", {31'h0, filt[ch]}, {31'h0, ~lvl});
        repeat (hi - lo) @(posedge pclk);
        check("filt late", {31'h0, filt[ch]}, {31'h0, lvl});
    endtask : step

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
        pstrb   = 4'h0;
        num_errors  = 0;
        check_count = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, byte strobes, unmapped and read-only places
        rd_chk(OFS_CFG, 32'h00000000, 1'b0);
        rd_chk(OFS_ROUTE, 32'h00000000, 1'b0);
        wr(OFS_CFG, 32'hFFFFFFFF, 4'h1, 1'b0);
        rd_chk(OFS_CFG, 32'h000000FF, 1'b0);
        wr(12'h010, 32'hFFFFFFFF, 4'hF, 1'b1);
        rd_chk(12'h010, 32'h00000000, 1'b1);
        wr(OFS_FILT, 32'hFFFFFFFF, 4'hF, 1'b0);
        rd_chk(OFS_FILT, 32'h00000000, 1'b0);
        // every input on the short setting: 100 ns rejected, 140 ns passed
        wr(OFS_CFG, 32'h15555555, 4'hF, 1'b0);
        for (int ch = 0; ch < NUM_CHAN; ch++) begin
            fork
                src.pulse(ch, 1'b1, 5);
                probe(ch, 14, any);
            join
            check("short reject", {31'h0, any}, 32'h00000000);
            fork
                src.pulse(ch, 1'b1, 7);
                probe(ch, 14, any);
            join
            check("short pass", {31'h0, any}, 32'h00000001);
        end
        // rise and fall after five samples, old level 4 cycles after the change, new level by 10
        step(0, 1'b1, 4, 10);
        step(0, 1'b0, 4, 10);
        // two-cycle dips restart the count, so four-cycle bursts never pass
        fork
            repeat (3) begin
                src.pulse(0, 1'b1, 4);
                @(posedge pclk);
            end
            probe(0, 30, any);
        join
        check("restart", {31'h0, any}, 32'h00000000);
        // mixed settings: off, mid, long on separate inputs; top bits read zero
        wr(OFS_CFG, 32'hF0002001, 4'hF, 1'b0);
        rd_chk(OFS_CFG, 32'h30002001, 1'b0);
        step(1, 1'b1, 0, 3);
        step(6, 1'b1, 300, 340);
        step(14, 1'b1, 22, 32);
        rd_chk(OFS_FILT, 32'h00004042, 1'b0);
        rd_chk(OFS_RAW, 32'h00004042, 1'b0);
        step(14, 1'b0, 22, 32);
        src.set_lvl(1, 1'b0);
        src.set_lvl(6, 1'b0);
        // direct routing passes the raw level while filters stay long
        wr(OFS_CFG, 32'h3FFFFFFF, 4'hF, 1'b0);
        wr(OFS_ROUTE, 32'h000008B2, 4'hF, 1'b0);
        rd_chk(OFS_ROUTE, 32'h000008B2, 1'b0);
        repeat (400) @(posedge pclk);
        src.set_lvl(2, 1'b1);
        repeat (3) @(posedge pclk);
        check("fwd trig out", {24'h0, fwd_trig_out}, 32'h00000008);
        check("fwd trig oe", {24'h0, fwd_trig_oe}, 32'h00000008);
        check("prog filt", {26'h0, prog_filt}, 32'h00000000);
        src.set_lvl(NUM_PROG, 1'b1);  // trigger line 0 is the routed source
        repeat (3) @(posedge pclk);
        check("fwd prog", {30'h0, fwd_prog_oe, fwd_prog_out}, 32'h00000003);
        check("trig filt", {24'h0, trig_filt}, 32'h00000000);
        print_verdict();
    end

    // cut a hang short well past the expected run length
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        print_verdict();
    end
endmodule : test_input_debounce_filter
